// >>> tb/usart_engine_model.sv
// behavioural shift engine model that stands on the far side of the port logic
`timescale 1ns/1ps

module usart_engine_model
	import usart_pkg::*;
(
	input wire logic i_ref_clk,
	input wire eng_cfg_s i_cfg,
	input wire logic i_rx_go,
	input wire logic [10:0] i_rx_word,
	output eng_evt_s o_evt
);
	int tx_cnt; // cycles left of the current shift out
	int rx_cnt; // cycles the receive completion is held
	logic [10:0] word_q = 11'h000; // stop, ninth bit and data of last receive

	// ----------------------------------------
	// sequencing of both directions
	// ----------------------------------------
	always @(posedge i_ref_clk) begin
		if (i_cfg.flush) begin
			// abort drops both directions at once
			tx_cnt <= 0;
			rx_cnt <= 0;
		end else begin
			if (i_cfg.tx_start) begin
				tx_cnt <= 12;
			end else if (tx_cnt > 0) begin
				tx_cnt <= tx_cnt - 1;
			end
			if (i_rx_go) begin
				rx_cnt <= 3;
				word_q <= i_rx_word;
			end else if (rx_cnt > 0) begin
				rx_cnt <= rx_cnt - 1;
			end
		end
	end

	// status toward the port; stale receive fields show the inverse
	always_comb begin
		o_evt = '0;
		o_evt.rx_done = (rx_cnt > 0);
		{o_evt.rx_stop, o_evt.rx_nine_bit_enable, o_evt.rx_data} = (rx_cnt > 0) ? word_q : ~word_q;
		o_evt.tx_done = (tx_cnt == 1) || (tx_cnt == 2);
		o_evt.tx_ready = (tx_cnt == 0); // slow: shifter refuses until tx_cnt is back at zero, done cycles included
		o_evt.busy = (tx_cnt > 2) || (rx_cnt > 0);
	end
endmodule // usart_engine_model

// >>> tb/usart_events_and_config_tb.sv
// self-checking bench of the port control, status and event logic
`timescale 1ns/1ps

module usart_events_and_config_tb import usart_pkg::*;;
	logic i_ref_clk;
	logic i_rst_b;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata;
	logic i_wr_en;
	logic i_rd_en;
	logic [DATA_W-1:0] o_rd_data;
	logic i_dma_wr_en;
	logic [DATA_W-1:0] i_dma_wdata;
	logic i_dma_rd_en;
	logic [DATA_W-1:0] o_dma_rdata;
	eng_evt_s evt; // engine status
	eng_cfg_s cfg; // engine configuration
	logic i_cts_b;
	logic o_rts_b, o_rx_irq, o_tx_irq, o_rx_dma, o_tx_dma, o_cpu_int;
	logic rx_go; // asks the model for one receive
	logic [10:0] rx_word; // stop, ninth bit, data
	int err_count, total_checks, tx_n, rx_n, fl_n, n;
	// reset table: address and value
	logic [7:0] adr [7] = '{CTRL_STATUS_ADDR, ASYNC_CTRL_ADDR, GENERIC_CTRL_ADDR, DATA_BUFFER_ADDR,
		RATE_MANTISSA_ADDR, IRQ_CTRL_ADDR, 8'h10};
	logic [7:0] rv [7] = '{CTRL_STATUS_RST, ASYNC_CTRL_RST, BYTE_RST, BYTE_RST, BYTE_RST, IRQ_CTRL_RST, 8'h00};
	// format table: async setting and ninth bit sent with byte 0x03
	logic [7:0] ac [4] = '{8'h32, 8'h12, 8'h3a, 8'h1a};
	logic eb [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

	usart_events_and_config i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
		.i_dma_wr_en(i_dma_wr_en), .i_dma_wdata(i_dma_wdata), .i_dma_rd_en(i_dma_rd_en),
		.o_dma_rdata(o_dma_rdata), .i_evt(evt), .o_cfg(cfg), .i_cts_b(i_cts_b), .o_rts_b(o_rts_b),
		.o_rx_irq(o_rx_irq), .o_tx_irq(o_tx_irq), .o_rx_dma(o_rx_dma), .o_tx_dma(o_tx_dma),
		.o_cpu_int(o_cpu_int));
	usart_engine_model i_eng (.i_ref_clk(i_ref_clk), .i_cfg(cfg), .i_rx_go(rx_go), .i_rx_word(rx_word),
		.o_evt(evt));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge i_ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr_en <= 1'b1;
		cyc(1);
		i_wr_en <= 1'b0;
		cyc(1);
	endtask
	// read data stand from the cycle after the strobe until the next read
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_addr <= a;
		i_rd_en <= 1'b1;
		cyc(1);
		i_rd_en <= 1'b0;
		#1;
		chk(o_rd_data, e);
		cyc(1);
	endtask
	task automatic rx(input logic [10:0] w);
		rx_word <= w;
		rx_go <= 1'b1;
		cyc(1);
		rx_go <= 1'b0;
		cyc(8);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// clock and watchdog
	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		cyc(20000);
		err_count++;
		end_of_test();
	end

	// event pulses: count them mid-cycle, dma triggers must equal requests
	always @(negedge i_ref_clk) begin
		if (i_rst_b) begin
			chk({o_tx_dma, o_rx_dma}, {o_tx_irq, o_rx_irq});
			tx_n += o_tx_irq;
			rx_n += o_rx_irq;
			fl_n += cfg.flush;
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{i_rst_b, i_wr_en, i_rd_en, i_dma_wr_en, i_dma_rd_en, rx_go} = '0;
		{i_addr, i_wdata, i_dma_wdata, rx_word} = '0;
		i_cts_b = 1'b1;
		cyc(6);
		i_rst_b <= 1'b1;
		cyc(1);
		chk(cfg.stop_level, 1'b1);
		chk(o_rts_b, 1'b0);
		for (int i = 0; i < 7; i++) rd(adr[i], rv[i]);
		// plain byte registers
		wr(GENERIC_CTRL_ADDR, 8'h3c);
		wr(RATE_MANTISSA_ADDR, 8'hc3);
		rd(GENERIC_CTRL_ADDR, 8'h3c);
		rd(RATE_MANTISSA_ADDR, 8'hc3);
		chk(cfg.mantissa, 8'hc3);
		chk(cfg.generic, 8'h3c);
		// modes and roles
		wr(CTRL_STATUS_ADDR, 8'h20);
		chk({cfg.uart_mode, cfg.target_role, cfg.rx_search}, 8'h03);
		wr(CTRL_STATUS_ADDR, 8'h80);
		chk({cfg.uart_mode, cfg.target_role, cfg.rx_search}, 8'h04);
		wr(CTRL_STATUS_ADDR, 8'hdf);
		chk(cfg.rx_search, 1'b1);
		rd(CTRL_STATUS_ADDR, 8'hc0);
		// character format and abort
		wr(ASYNC_CTRL_ADDR, 8'h7f);
		rd(ASYNC_CTRL_ADDR, 8'h7f);
		chk({cfg.nine_bit_enable, cfg.two_stop_select, cfg.stop_level, cfg.start_level}, 8'h0f);
		wr(ASYNC_CTRL_ADDR, 8'h80);
		rd(ASYNC_CTRL_ADDR, 8'h00);
		chk({fl_n[3:0], cfg.stop_level, cfg.start_level}, 8'h04);
		// transmit with every ninth bit source
		wr(IRQ_CTRL_ADDR, 8'h03);
		for (int i = 0; i < 4; i++) begin
			wr(ASYNC_CTRL_ADDR, ac[i]);
			wr(DATA_BUFFER_ADDR, 8'h03);
			#1;
			chk(o_tx_irq, 1'b1);
			cyc(1);
			#1;
			chk(o_tx_irq, 1'b0);
			cyc(15);
			chk(cfg.tx_data, 8'h03);
			chk(cfg.tx_nine_bit_enable, eb[i]);
		end
		chk(tx_n, 4);
		rd(IRQ_CTRL_ADDR, 8'h0b);
		chk(o_cpu_int, 1'b1);
		rd(CTRL_STATUS_ADDR, 8'hc2);
		wr(IRQ_CTRL_ADDR, 8'h09);
		chk(o_cpu_int, 1'b0);
		wr(IRQ_CTRL_ADDR, 8'h03);
		rd(IRQ_CTRL_ADDR, 8'h03);
		wr(CTRL_STATUS_ADDR, 8'hc0);
		// busy while the byte goes out
		wr(DATA_BUFFER_ADDR, 8'h55);
		rd(CTRL_STATUS_ADDR, 8'hc1);
		cyc(16);
		rd(CTRL_STATUS_ADDR, 8'hc2);
		// handshake hold, abort, then a dma write
		wr(ASYNC_CTRL_ADDR, 8'h42);
		n = tx_n;
		wr(DATA_BUFFER_ADDR, 8'h66);
		cyc(4);
		chk(tx_n - n, 0);
		wr(ASYNC_CTRL_ADDR, 8'hc2);
		i_cts_b <= 1'b0;
		cyc(4);
		chk(tx_n - n, 0);
		i_dma_wdata <= 8'h99;
		i_dma_wr_en <= 1'b1;
		cyc(1);
		i_dma_wr_en <= 1'b0;
		cyc(3);
		chk(tx_n - n, 1);
		chk(cfg.tx_data, 8'h99);
		cyc(16);
		wr(ASYNC_CTRL_ADDR, 8'h02);
		i_cts_b <= 1'b1;
		wr(CTRL_STATUS_ADDR, 8'hc0);
		// receive, dma read, framing and parity faults
		rx({2'b11, 1'b0, 8'h5a});
		// byte waiting with flow on: request to send goes inactive
		wr(ASYNC_CTRL_ADDR, 8'h42);
		chk(o_rts_b, 1'b1);
		wr(ASYNC_CTRL_ADDR, 8'h02);
		rd(CTRL_STATUS_ADDR, 8'hc4);
		rd(IRQ_CTRL_ADDR, 8'h0f);
		i_dma_rd_en <= 1'b1;
		cyc(1);
		i_dma_rd_en <= 1'b0;
		#1;
		chk(o_dma_rdata, 8'h5a);
		cyc(1);
		rd(CTRL_STATUS_ADDR, 8'hc0);
		rx({2'b00, 1'b0, 8'h11});
		rd(DATA_BUFFER_ADDR, 8'h11);
		rd(CTRL_STATUS_ADDR, 8'hd0);
		rx({2'b00, 1'b0, 8'h12});
		wr(CTRL_STATUS_ADDR, 8'hc0);
		rd(CTRL_STATUS_ADDR, 8'hc0);
		wr(ASYNC_CTRL_ADDR, 8'h1a);
		rx({2'b11, 1'b0, 8'h03});
		rd(CTRL_STATUS_ADDR, 8'hcc);
		rx({2'b11, 1'b1, 8'h03});
		rd(CTRL_STATUS_ADDR, 8'hc4);
		chk(rx_n, 5);
		end_of_test();
	end
endmodule // usart_events_and_config_tb

// >>> verilog/usart_events_and_config.sv
// control, status, configuration and event logic of one serial port
`timescale 1ns/1ps

module usart_events_and_config
	import usart_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	output logic [DATA_W-1:0] o_rd_data,
	input wire logic i_dma_wr_en,
	input wire logic [DATA_W-1:0] i_dma_wdata,
	input wire logic i_dma_rd_en,
	output logic [DATA_W-1:0] o_dma_rdata,
	input wire eng_evt_s i_evt,
	output eng_cfg_s o_cfg,
	input wire logic i_cts_b,
	output logic o_rts_b,
	output logic o_rx_irq,
	output logic o_tx_irq,
	output logic o_rx_dma,
	output logic o_tx_dma,
	output logic o_cpu_int
);

	// ----------------------------------------------------------------
	// state of the block
	// ----------------------------------------------------------------
	typedef struct packed {
		logic mode; // async character mode
		logic rx_on; // receiver enabled
		logic target; // clock follower
		logic framing_fault; // stop level wrong
		logic parity_fault; // parity mismatch
		logic rx_byte; // received byte waiting
		logic tx_byte; // last byte sent
		logic flow; // handshake enabled
		logic ninth_bit_value; // ninth bit or parity sense
		logic nine_bit_enable; // nine-bit characters
		logic parity_on; // parity enabled
		logic two_stop_select; // two stop bits
		logic stop_level; // stop bit level
		logic start_level; // start bit level
		logic [7:0] generic; // generic control byte
		logic [7:0] mantissa; // baud mantissa byte
		logic [7:0] tx_hold; // written, not yet handed over
		logic [7:0] tx_out; // handed to the transmitter
		logic tx_nine_bit_enable; // ninth bit handed over
		logic [7:0] rx_hold; // last received byte
		txb_state_e txb; // holding buffer state
		logic tx_start; // start command pulse
		logic flush; // abort command pulse
		logic rx_mask; // rx event enable
		logic tx_mask; // tx event enable
		logic rx_pending; // rx event pending
		logic tx_pending; // tx event pending
		logic [7:0] rdata; // cpu read data
		logic [7:0] dma_rdata; // dma read data
	} state_s;

	state_s st_q; // current state
	state_s st_d; // next state
	logic rx_pulse; // one-cycle receive completion
	logic tx_done_pulse; // one-cycle transmit completion
	logic cts_ok; // transmitter may start
	logic handoff; // holding byte moves to the shifter
	logic wr_ctrl; // cpu write to ctrl_status_reg
	logic wr_async; // cpu write to async_ctrl_reg
	logic wr_buf; // cpu or dma write to data_buffer_reg
	logic rd_buf; // cpu or dma read of data_buffer_reg
	logic [7:0] buf_wdata; // data for a buffer write
	logic [7:0] ctrl_view; // ctrl_status_reg as read
	logic [7:0] async_view; // async_ctrl_reg as read
	logic [7:0] irq_view; // event register as read
	logic [7:0] rd_val; // selected read value
	logic rx_parity_bad; // parity check of the arriving byte
	logic rx_frame_bad; // stop check of the arriving byte

	// ----------------------------------------------------------------
	// event pulse shaping
	// ----------------------------------------------------------------
	usart_pulse_gen u_rx_pulse (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_level(i_evt.rx_done),
		.o_pulse(rx_pulse)
	);

	usart_pulse_gen u_tx_pulse (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_level(i_evt.tx_done),
		.o_pulse(tx_done_pulse)
	);

	// ----------------------------------------------------------------
	// decode and views
	// ----------------------------------------------------------------
	// cpu wins a buffer write when both masters write in one cycle
	always_comb begin
		wr_ctrl = i_wr_en && (i_addr == CTRL_STATUS_ADDR);
		wr_async = i_wr_en && (i_addr == ASYNC_CTRL_ADDR);
		wr_buf = (i_wr_en && (i_addr == DATA_BUFFER_ADDR)) || i_dma_wr_en;
		rd_buf = (i_rd_en && (i_addr == DATA_BUFFER_ADDR)) || i_dma_rd_en;
		buf_wdata = (i_wr_en && (i_addr == DATA_BUFFER_ADDR)) ? i_wdata : i_dma_wdata;
		cts_ok = !st_q.flow || !i_cts_b;
		handoff = (st_q.txb == TXB_FULL) && i_evt.tx_ready && cts_ok
			&& !(wr_async && i_wdata[AC_FLUSH]);
		// parity over data and ninth bit: even sense wants zero ones-parity
		rx_parity_bad = st_q.nine_bit_enable && st_q.parity_on
			&& ((^{i_evt.rx_data, i_evt.rx_nine_bit_enable}) ^ ~st_q.ninth_bit_value);
		rx_frame_bad = (i_evt.rx_stop[0] != st_q.stop_level)
			|| (st_q.two_stop_select && (i_evt.rx_stop[1] != st_q.stop_level));
	end

	// register views, abort bit always reads zero
	always_comb begin
		ctrl_view = '0;
		ctrl_view[CS_MODE] = st_q.mode;
		ctrl_view[CS_RX_ON] = st_q.rx_on;
		ctrl_view[CS_TARGET] = st_q.target;
		ctrl_view[CS_FRAMING] = st_q.framing_fault;
		ctrl_view[CS_PARITY] = st_q.parity_fault;
		ctrl_view[CS_RX_BYTE] = st_q.rx_byte;
		ctrl_view[CS_TX_BYTE] = st_q.tx_byte;
		ctrl_view[CS_ACTIVE] = i_evt.busy || st_q.tx_start;
		async_view = '0;
		async_view[AC_FLOW] = st_q.flow;
		async_view[AC_NINTH] = st_q.ninth_bit_value;
		async_view[AC_NINE] = st_q.nine_bit_enable;
		async_view[AC_PARITY] = st_q.parity_on;
		async_view[AC_TWO_STOP] = st_q.two_stop_select;
		async_view[AC_STOP_LVL] = st_q.stop_level;
		async_view[AC_START_LVL] = st_q.start_level;
		irq_view = '0;
		irq_view[IR_RX_MASK] = st_q.rx_mask;
		irq_view[IR_TX_MASK] = st_q.tx_mask;
		irq_view[IR_RX_PEND] = st_q.rx_pending;
		irq_view[IR_TX_PEND] = st_q.tx_pending;
		// five port registers plus the event register
		case (i_addr)
			CTRL_STATUS_ADDR: rd_val = ctrl_view;
			ASYNC_CTRL_ADDR: rd_val = async_view;
			GENERIC_CTRL_ADDR: rd_val = st_q.generic;
			DATA_BUFFER_ADDR: rd_val = st_q.rx_hold;
			RATE_MANTISSA_ADDR: rd_val = st_q.mantissa;
			IRQ_CTRL_ADDR: rd_val = irq_view;
			default: rd_val = '0; // unmapped reads zero
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.tx_start = 1'b0;
		st_d.flush = 1'b0;
		// read data and read side effects
		if (i_rd_en) begin
			st_d.rdata = rd_val;
			if (i_addr == CTRL_STATUS_ADDR) begin
				st_d.framing_fault = 1'b0;
				st_d.parity_fault = 1'b0;
			end
		end
		if (i_dma_rd_en) begin
			st_d.dma_rdata = st_q.rx_hold;
		end
		if (rd_buf) begin
			st_d.rx_byte = 1'b0;
		end
		// control and status writes, flags clear on zero only
		if (wr_ctrl) begin
			st_d.mode = i_wdata[CS_MODE];
			st_d.rx_on = i_wdata[CS_RX_ON];
			st_d.target = i_wdata[CS_TARGET];
			if (!i_wdata[CS_FRAMING]) begin
				st_d.framing_fault = 1'b0;
			end
			if (!i_wdata[CS_PARITY]) begin
				st_d.parity_fault = 1'b0;
			end
			if (!i_wdata[CS_RX_BYTE]) begin
				st_d.rx_byte = 1'b0;
			end
			if (!i_wdata[CS_TX_BYTE]) begin
				st_d.tx_byte = 1'b0;
			end
		end
		// character format writes
		if (wr_async) begin
			st_d.flow = i_wdata[AC_FLOW];
			st_d.ninth_bit_value = i_wdata[AC_NINTH];
			st_d.nine_bit_enable = i_wdata[AC_NINE];
			st_d.parity_on = i_wdata[AC_PARITY];
			st_d.two_stop_select = i_wdata[AC_TWO_STOP];
			st_d.stop_level = i_wdata[AC_STOP_LVL];
			st_d.start_level = i_wdata[AC_START_LVL];
			if (i_wdata[AC_FLUSH]) begin
				st_d.flush = 1'b1;
				st_d.txb = TXB_EMPTY;
				st_d.rx_byte = 1'b0;
			end
		end
		if (i_wr_en && (i_addr == GENERIC_CTRL_ADDR)) begin
			st_d.generic = i_wdata;
		end
		if (i_wr_en && (i_addr == RATE_MANTISSA_ADDR)) begin
			st_d.mantissa = i_wdata;
		end
		// event register: masks plain, pending flags clear on zero
		if (i_wr_en && (i_addr == IRQ_CTRL_ADDR)) begin
			st_d.rx_mask = i_wdata[IR_RX_MASK];
			st_d.tx_mask = i_wdata[IR_TX_MASK];
			if (!i_wdata[IR_RX_PEND]) begin
				st_d.rx_pending = 1'b0;
			end
			if (!i_wdata[IR_TX_PEND]) begin
				st_d.tx_pending = 1'b0;
			end
		end
		// holding byte moves on, ninth bit from value or parity
		if (handoff) begin
			st_d.txb = TXB_EMPTY;
			st_d.tx_start = 1'b1;
			st_d.tx_out = st_q.tx_hold;
			if (st_q.parity_on) begin
				st_d.tx_nine_bit_enable = (^st_q.tx_hold) ^ ~st_q.ninth_bit_value;
			end else begin
				st_d.tx_nine_bit_enable = st_q.ninth_bit_value;
			end
			st_d.tx_pending = 1'b1;
		end
		// a new byte fills the holding buffer, even during a handoff
		if (wr_buf) begin
			st_d.tx_hold = buf_wdata;
			st_d.txb = TXB_FULL;
			st_d.tx_byte = 1'b0;
		end
		// engine events come last so a set beats any clear
		if (rx_pulse) begin
			st_d.rx_hold = i_evt.rx_data;
			st_d.rx_byte = 1'b1;
			st_d.rx_pending = 1'b1;
			if (rx_parity_bad) begin
				st_d.parity_fault = 1'b1;
			end
			if (rx_frame_bad && st_q.mode) begin
				st_d.framing_fault = 1'b1;
			end
		end
		if (tx_done_pulse) begin
			st_d.tx_byte = 1'b1;
		end
	end

	// state register
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			st_q <= '0;
			st_q.stop_level <= ASYNC_CTRL_RST[AC_STOP_LVL];
			st_q.tx_hold <= BYTE_RST;
			st_q.rx_hold <= BYTE_RST;
			st_q.txb <= TXB_EMPTY;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb begin
		o_cfg.uart_mode = st_q.mode;
		o_cfg.rx_search = st_q.rx_on || !st_q.mode;
		o_cfg.target_role = st_q.target;
		o_cfg.nine_bit_enable = st_q.nine_bit_enable;
		o_cfg.two_stop_select = st_q.two_stop_select;
		o_cfg.stop_level = st_q.stop_level;
		o_cfg.start_level = st_q.start_level;
		o_cfg.generic = st_q.generic;
		o_cfg.mantissa = st_q.mantissa;
		o_cfg.tx_data = st_q.tx_out;
		o_cfg.tx_nine_bit_enable = st_q.tx_nine_bit_enable;
		o_cfg.tx_start = st_q.tx_start;
		o_cfg.flush = st_q.flush;
	end

	// with flow on, request to send low while the receive byte is free and reception on; always low with flow off
	assign o_rts_b = st_q.flow ? !(st_q.rx_on && !st_q.rx_byte) : 1'b0;
	assign o_rd_data = st_q.rdata;
	assign o_dma_rdata = st_q.dma_rdata;
	assign o_rx_irq = rx_pulse;
	assign o_tx_irq = st_q.tx_start;
	assign o_rx_dma = rx_pulse;
	assign o_tx_dma = st_q.tx_start;
	assign o_cpu_int = (st_q.rx_pending && st_q.rx_mask) || (st_q.tx_pending && st_q.tx_mask);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	rx_pulse_single_a: assert property (o_rx_irq |=> !o_rx_irq)
		else $error("receive event longer than one cycle");
	event_dma_pair_a: assert property ((o_rx_irq == o_rx_dma) && (o_tx_irq == o_tx_dma))
		else $error("dma trigger differs from request");
	rx_pending_set_a: assert property (o_rx_irq |=> st_q.rx_pending && st_q.rx_byte)
		else $error("receive event lost");
	gated_int_a: assert property (o_tx_irq && st_q.tx_mask && !(i_wr_en && (i_addr == IRQ_CTRL_ADDR)) |=> o_cpu_int)
		else $error("enabled transmit event raised no interrupt");
	flush_reads_zero_a: assert property (i_rd_en && (i_addr == ASYNC_CTRL_ADDR) |=> !o_rd_data[AC_FLUSH])
		else $error("abort bit read back as one");
	busy_read_a: assert property (i_rd_en && (i_addr == CTRL_STATUS_ADDR) && i_evt.busy |=> o_rd_data[CS_ACTIVE])
		else $error("busy not shown");
	cts_wait_a: assert property (o_cfg.tx_start && $past(st_q.flow) |-> $past(!i_cts_b))
		else $error("transmit started without clear to send");
	ninth_value_a: assert property (o_cfg.tx_start && !$past(st_q.parity_on)
		|-> o_cfg.tx_nine_bit_enable == $past(st_q.ninth_bit_value))
		else $error("ninth bit not taken from its value bit");
	parity_sense_a: assert property (o_cfg.tx_start && $past(st_q.parity_on)
		|-> o_cfg.tx_nine_bit_enable == ((^o_cfg.tx_data) ^ ~$past(st_q.ninth_bit_value)))
		else $error("wrong transmit parity");
	frame_flag_a: assert property (rx_pulse && rx_frame_bad && st_q.mode |=> st_q.framing_fault)
		else $error("framing fault not flagged");
	parity_flag_a: assert property (rx_pulse && rx_parity_bad |=> st_q.parity_fault)
		else $error("parity fault not flagged");

	rx_event_c: cover property (o_rx_irq ##1 i_rd_en && (i_addr == DATA_BUFFER_ADDR));
	tx_handoff_c: cover property (wr_buf ##[1:20] o_tx_irq);
	flush_c: cover property (o_cfg.flush);

endmodule // usart_events_and_config

// >>> verilog/usart_pkg.sv
// shared constants and carrier types of the serial port control block
package usart_pkg;

	// ----------------------------------------------------------------
	// register bus geometry and register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8; // register address width
	localparam int unsigned DATA_W = 8; // register data width
	localparam logic [ADDR_W-1:0] CTRL_STATUS_ADDR = 8'h86; // ctrl_status_reg
	localparam logic [ADDR_W-1:0] ASYNC_CTRL_ADDR = 8'hc4; // async_ctrl_reg
	localparam logic [ADDR_W-1:0] GENERIC_CTRL_ADDR = 8'hc5; // generic_ctrl_reg
	localparam logic [ADDR_W-1:0] DATA_BUFFER_ADDR = 8'hc1; // data_buffer_reg
	localparam logic [ADDR_W-1:0] RATE_MANTISSA_ADDR = 8'hc2; // rate_mantissa_reg
	localparam logic [ADDR_W-1:0] IRQ_CTRL_ADDR = 8'he0; // event masks and pending flags

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CS_MODE = 7; // 1 async character mode, 0 synchronous
	localparam int CS_RX_ON = 6; // receiver enable
	localparam int CS_TARGET = 5; // 0 clock master, 1 clock follower
	localparam int CS_FRAMING = 4; // framing_fault
	localparam int CS_PARITY = 3; // parity fault
	localparam int CS_RX_BYTE = 2; // received byte ready
	localparam int CS_TX_BYTE = 1; // last byte sent
	localparam int CS_ACTIVE = 0; // busy, read only
	localparam int AC_FLUSH = 7; // abort, reads zero
	localparam int AC_FLOW = 6; // handshake enable
	localparam int AC_NINTH = 5; // ninth_bit_value / parity sense
	localparam int AC_NINE = 4; // nine_bit_enable
	localparam int AC_PARITY = 3; // parity enable
	localparam int AC_TWO_STOP = 2; // two_stop_select
	localparam int AC_STOP_LVL = 1; // stop bit level
	localparam int AC_START_LVL = 0; // start bit level
	localparam int IR_RX_MASK = 0; // rx event enable
	localparam int IR_TX_MASK = 1; // tx event enable
	localparam int IR_RX_PEND = 2; // rx pending flag
	localparam int IR_TX_PEND = 3; // tx pending flag

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] CTRL_STATUS_RST = 8'h00;
	localparam logic [DATA_W-1:0] ASYNC_CTRL_RST = 8'h02; // stop level resets high
	localparam logic [DATA_W-1:0] BYTE_RST = 8'h00; // generic, mantissa, data
	localparam logic [DATA_W-1:0] IRQ_CTRL_RST = 8'h00;

	// transmit holding buffer state
	typedef enum logic {TXB_EMPTY, TXB_FULL} txb_state_e;

	// status reported by the shift engines
	typedef struct packed {
		logic rx_done; // receive finished (level or pulse)
		logic [7:0] rx_data; // received byte
		logic rx_nine_bit_enable; // received ninth bit
		logic [1:0] rx_stop; // sampled stop bits, [0] first
		logic tx_done; // transmit finished (level or pulse)
		logic tx_ready; // shifter can take a byte
		logic busy; // shifting in either direction
	} eng_evt_s;

	// configuration and commands to the shift engines
	typedef struct packed {
		logic uart_mode; // async character mode
		logic rx_search; // receiver may hunt for a start bit
		logic target_role; // synchronous clock follower
		logic nine_bit_enable; // nine data bits
		logic two_stop_select; // two stop bits on transmit
		logic stop_level; // stop bit level
		logic start_level; // start bit level, idle is opposite
		logic [7:0] generic; // generic control byte
		logic [7:0] mantissa; // baud mantissa byte
		logic [7:0] tx_data; // byte handed to the transmitter
		logic tx_nine_bit_enable; // ninth bit handed to the transmitter
		logic tx_start; // one-cycle start command
		logic flush; // one-cycle abort command
	} eng_cfg_s;

endpackage

// >>> verilog/usart_pulse_gen.sv
// rising edge to single-cycle pulse converter for engine events
`timescale 1ns/1ps

module usart_pulse_gen (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_level,
	output logic o_pulse
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic prev; // input seen last cycle
		logic pulse; // registered pulse
	} pulse_state_s;

	pulse_state_s st_q; // current state
	pulse_state_s st_d; // next state

	// edge detection, one pulse per rising edge of the input
	always_comb begin
		st_d = st_q;
		st_d.prev = i_level;
		st_d.pulse = i_level & ~st_q.prev;
	end

	// state register
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_pulse = st_q.pulse;

endmodule // usart_pulse_gen
